// ---- logic/slim_line_if.sv ----
// serial line interface: sync tx/rx, async start/stop tx/rx, register port
//
// Implementation choices: the address-and-strobe port and the address map.
`include "slim_defs.svh"

module slim_line_if
	import slim_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic stx_clk,
	output logic stx_line,
	input wire logic srx_clk,
	input wire logic srx_data,
	input wire logic tick,
	input wire logic arx_line,
	output logic atx_line,
	output logic cycle_req
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// each pin: two stages, third stage only for edge finding
	logic [4:0] pin_in;
	logic [4:0] pin_s1_r;
	logic [4:0] pin_s2_r;
	logic [4:0] pin_s3_r;
	assign pin_in = {arx_line, tick, srx_data, srx_clk, stx_clk};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					pin_s1_r[gi] <= 1'b1;
					pin_s2_r[gi] <= 1'b1;
					pin_s3_r[gi] <= 1'b1;
				end else if (ce) begin
					pin_s1_r[gi] <= pin_in[gi];
					pin_s2_r[gi] <= pin_s1_r[gi];
					pin_s3_r[gi] <= pin_s2_r[gi];
				end
			end
		end
	endgenerate
	logic stx_rise;
	logic srx_rise;
	logic srx_bit;
	logic tick_rise;
	logic arx_bit;
	assign stx_rise = pin_s2_r[0] & ~pin_s3_r[0];
	assign srx_rise = pin_s2_r[1] & ~pin_s3_r[1];
	assign srx_bit = pin_s2_r[2];
	assign tick_rise = pin_s2_r[3] & ~pin_s3_r[3];
	assign arx_bit = pin_s2_r[4];

	// ----------------------------------------
	// register port decode
	// ----------------------------------------
	slim_req_s req;
	assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
	logic [1:0] len_r;
	logic [3:0] len;
	logic [3:0] ind;
	assign len = `SLIM_LEN_BASE + {2'h0, len_r};
	assign ind = len + 4'h1;
	logic wr_ctrl;
	logic wr_status;
	logic wr_stx;
	logic wr_atx;
	logic wr_aclr;
	logic rd_srx;
	assign wr_ctrl = ce & req.wr & (req.addr == `SLIM_OFF_CTRL);
	assign wr_status = ce & req.wr & (req.addr == `SLIM_OFF_STATUS);
	assign wr_stx = ce & req.wr & (req.addr == `SLIM_OFF_STX_DATA);
	assign wr_atx = ce & req.wr & (req.addr == `SLIM_OFF_ATX_DATA);
	assign wr_aclr = ce & req.wr & (req.addr == `SLIM_OFF_ARX_CLEAR);
	assign rd_srx = ce & req.rd & (req.addr == `SLIM_OFF_SRX_DATA);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			len_r <= `SLIM_CTRL_LEN_RST;
		end else if (wr_ctrl) begin
			len_r <= req.wdata[`SLIM_CTRL_LEN_HI:`SLIM_CTRL_LEN_LO];
		end
	end

	// ----------------------------------------
	// synchronous transmitter
	// ----------------------------------------
	logic [9:0] stx_sr_r;
	logic stx_empty;
	logic stx_load;
	logic stx_shift;
	assign stx_empty = (stx_sr_r[9:2] == 8'h00);
	assign stx_load = wr_stx & stx_empty;
	// shifting stops once the marker sits in the line stage (bit 0), so the line rests at mark
	assign stx_shift = ce & stx_rise & (|stx_sr_r[9:1]);
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stx_sr_r <= `SLIM_STX_RST;
		end else if (stx_load) begin
			stx_sr_r <= {1'b1, req.wdata, stx_sr_r[0]};
		end else if (stx_shift) begin
			stx_sr_r <= {1'b0, stx_sr_r[9:1]};
		end
	end
	assign stx_line = stx_sr_r[0];

	// ----------------------------------------
	// synchronous receiver
	// ----------------------------------------
	logic [8:0] srx_sr_r;
	logic srx_frame_r;
	logic srv_req_r;
	logic srx_full;
	logic [8:0] srx_next;
	logic srx_lock_evt;
	assign srx_full = srx_frame_r & srx_sr_r[8];
	assign srx_next = {srx_sr_r[7:0], srx_bit};
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			srx_sr_r <= `SLIM_SRX_MARK;
			srx_frame_r <= 1'b0;
		end else if (wr_ctrl & req.wdata[`SLIM_CTRL_REFRAME] & ~srx_lock_evt) begin
			srx_frame_r <= 1'b0;
		end else if (rd_srx & srx_full) begin
			srx_sr_r <= `SLIM_SRX_MARK;
		end else if (ce & srx_rise & ~srx_full) begin
			if (!srx_frame_r && srx_next[7:0] == `SLIM_IDLE_CHAR) begin
				srx_frame_r <= 1'b1;
				srx_sr_r <= `SLIM_SRX_MARK;
			end else begin
				srx_sr_r <= srx_next;
			end
		end
	end
	// a lock in the same cycle as a reframe write wins over the reframe
	assign srx_lock_evt = ce & srx_rise & ~srx_full & ~srx_frame_r & (srx_next[7:0] == `SLIM_IDLE_CHAR);
	// sticky; a new request in the clearing cycle survives
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			srv_req_r <= 1'b0;
		end else if (srx_lock_evt) begin
			srv_req_r <= 1'b1;
		end else if (wr_status & req.wdata[`SLIM_STATUS_SRV]) begin
			srv_req_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// asynchronous receiver
	// ----------------------------------------
	logic [9:0] arx_sr_r;
	logic [7:0] arx_cnt_r;
	logic arx_run_r;
	logic arx_frame_r;
	logic arx_full_r;
	logic arx_done;
	assign arx_done = arx_run_r & ~arx_frame_r & ~arx_sr_r[ind];
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			arx_sr_r <= `SLIM_ASY_RST;
			arx_cnt_r <= 8'h00;
			arx_run_r <= 1'b0;
			arx_frame_r <= 1'b0;
			arx_full_r <= 1'b0;
		end else if (wr_aclr & ~arx_done) begin
			// a character finishing in the clear cycle is kept, set wins
			arx_sr_r <= `SLIM_ASY_RST;
			arx_full_r <= 1'b0;
			arx_run_r <= 1'b0;
			arx_frame_r <= 1'b0;
			arx_cnt_r <= 8'h00;
		end else if (ce) begin
			if (arx_done) begin
				arx_run_r <= 1'b0;
				arx_full_r <= 1'b1;
				arx_cnt_r <= 8'h00;
			end else if (!arx_run_r) begin
				// held full, no new hunt until cleared
				if (!arx_full_r && !arx_bit) begin
					arx_run_r <= 1'b1;
					arx_cnt_r <= 8'h00;
				end
			end else if (!arx_frame_r) begin
				if (arx_bit) begin
					arx_run_r <= 1'b0;
					arx_cnt_r <= 8'h00;
				end else if (tick_rise) begin
					if (arx_cnt_r == `SLIM_ASY_HALF - 8'h01) begin
						arx_sr_r <= {arx_sr_r[8:0], arx_bit};
						arx_frame_r <= 1'b1;
						arx_cnt_r <= 8'h00;
					end else begin
						arx_cnt_r <= arx_cnt_r + 8'h01;
					end
				end
			end else if (tick_rise) begin
				if (arx_cnt_r == `SLIM_ASY_N - 8'h01) begin
					arx_sr_r <= {arx_sr_r[8:0], arx_bit};
					arx_cnt_r <= 8'h00;
					if (!arx_sr_r[ind - 4'h1]) begin
						arx_frame_r <= 1'b0;
					end
				end else begin
					arx_cnt_r <= arx_cnt_r + 8'h01;
				end
			end
		end
	end
	logic [7:0] arx_data;
	always_comb begin
		arx_data = 8'h00;
		for (int k = 0; k < 8; k++) begin
			if (4'(k) < len) begin
				arx_data[k] = arx_sr_r[len - 4'(k)];
			end
		end
	end

	// ----------------------------------------
	// asynchronous transmitter
	// ----------------------------------------
	slim_atx_e atx_st_r;
	logic [7:0] atx_cnt_r;
	logic [7:0] atx_hold_r;
	logic [9:0] atx_sr_r;
	logic [3:0] atx_bits_r;
	logic atx_bit_evt;
	logic atx_empty;
	logic [9:0] atx_frame;
	assign atx_empty = (atx_st_r == ATX_IDLE);
	assign atx_bit_evt = ce & tick_rise & (atx_cnt_r == `SLIM_ASY_N - 8'h01) & ~atx_empty;
	always_comb begin
		atx_frame = `SLIM_ASY_RST;
		atx_frame[0] = 1'b0;
		for (int k = 0; k < 8; k++) begin
			if (4'(k) < len) begin
				atx_frame[k + 1] = atx_hold_r[k];
			end
		end
	end
	// counter only sees timing pulses while a character is offered
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			atx_cnt_r <= 8'h00;
		end else if (ce) begin
			if (atx_empty || atx_bit_evt) begin
				atx_cnt_r <= 8'h00;
			end else if (tick_rise) begin
				atx_cnt_r <= atx_cnt_r + 8'h01;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			atx_st_r <= ATX_IDLE;
			atx_hold_r <= 8'h00;
			atx_sr_r <= `SLIM_ASY_RST;
			atx_bits_r <= 4'h0;
		end else if (ce) begin
			case (atx_st_r)
				ATX_IDLE: begin
					if (wr_atx) begin
						atx_hold_r <= req.wdata;
						atx_st_r <= ATX_WAIT;
					end
				end
				ATX_WAIT: begin
					if (atx_bit_evt) begin
						atx_st_r <= ATX_PULSE;
					end
				end
				ATX_PULSE: begin
					if (atx_bit_evt) begin
						atx_sr_r <= atx_frame;
						atx_bits_r <= 4'h0;
						atx_st_r <= ATX_SEND;
					end
				end
				ATX_SEND: begin
					if (atx_bit_evt) begin
						atx_sr_r <= {1'b1, atx_sr_r[9:1]};
						atx_bits_r <= atx_bits_r + 4'h1;
						if (atx_bits_r == len) begin
							atx_st_r <= ATX_IDLE;
						end
					end
				end
				default: begin
					atx_st_r <= ATX_IDLE;
				end
			endcase
		end
	end
	assign atx_line = atx_sr_r[0];

	// ----------------------------------------
	// status, read data, memory request
	// ----------------------------------------
	slim_status_s status;
	assign status = '{srv_req: srv_req_r, srx_frame: srx_frame_r, srx_full: srx_full,
		arx_full: arx_full_r, atx_empty: atx_empty, stx_empty: stx_empty};
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata <= 8'h00;
		end else if (ce) begin
			rdata <= 8'h00;
			if (req.rd) begin
				case (req.addr)
					`SLIM_OFF_CTRL: rdata <= {5'h00, len_r, 1'b0};
					`SLIM_OFF_STATUS: rdata <= {2'h0, status};
					`SLIM_OFF_SRX_DATA: rdata <= srx_sr_r[7:0];
					`SLIM_OFF_ARX_DATA: rdata <= arx_data;
					default: rdata <= 8'h00;
				endcase
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cycle_req <= 1'b0;
		end else if (ce) begin
			cycle_req <= stx_empty | atx_empty | arx_full_r | srx_full;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_stx_load;
		stx_load |=> stx_sr_r[9] && !stx_empty && $stable(stx_sr_r[0]);
	endproperty
	a_stx_load: assert property (p_stx_load) else $error("sync tx load bad");

	property p_stx_hold;
		!stx_rise && !stx_load && !$past(stx_load) |=> $stable(stx_sr_r);
	endproperty
	a_stx_hold: assert property (p_stx_hold) else $error("sync tx moved without line clock");

	property p_stx_shift;
		stx_shift && !stx_load |=> !stx_sr_r[9] && stx_line == $past(stx_sr_r[1]);
	endproperty
	a_stx_shift: assert property (p_stx_shift) else $error("sync tx shift bad");

	property p_arx_noise;
		ce && arx_run_r && !arx_frame_r && arx_bit && !arx_done && !wr_aclr |=> !arx_run_r && arx_cnt_r == 8'h00;
	endproperty
	a_arx_noise: assert property (p_arx_noise) else $error("noise not rejected");

	property p_arx_done;
		ce && arx_done |=> arx_full_r && !arx_run_r ##1 !arx_run_r;
	endproperty
	a_arx_done: assert property (p_arx_done) else $error("receive end bad");

	property p_arx_clear;
		wr_aclr && !arx_done |=> !arx_full_r && arx_sr_r == `SLIM_ASY_RST;
	endproperty
	a_arx_clear: assert property (p_arx_clear) else $error("clear pulse ignored");

	property p_atx_offer;
		ce && atx_empty && wr_atx |=> atx_st_r == ATX_WAIT && atx_line;
	endproperty
	a_atx_offer: assert property (p_atx_offer) else $error("offer not taken");

	property p_atx_end;
		atx_st_r == ATX_SEND && atx_bit_evt && atx_bits_r == len |=> atx_empty && atx_line && atx_cnt_r == 8'h00;
	endproperty
	a_atx_end: assert property (p_atx_end) else $error("stop handling bad");

	property p_atx_start;
		atx_st_r == ATX_PULSE && atx_bit_evt |=> !atx_line && atx_st_r == ATX_SEND;
	endproperty
	a_atx_start: assert property (p_atx_start) else $error("start bit missing");

	property p_req;
		reset_n && ce && stx_empty ##1 ce |-> cycle_req;
	endproperty
	a_req: assert property (p_req) else $error("no memory request");

	c_stx_char: cover property (stx_load ##[1:400] stx_empty);
	c_arx_char: cover property (arx_done);
	c_atx_char: cover property (atx_st_r == ATX_SEND ##[1:600] atx_empty);
	c_srx_lock: cover property (srx_lock_evt);
endmodule

// ---- logic/slim_defs.svh ----
// offsets, field positions, reset values and timing counts of the line interface
`ifndef SLIM_DEFS_SVH
`define SLIM_DEFS_SVH
`define SLIM_OFF_CTRL 4'h0
`define SLIM_OFF_STATUS 4'h1
`define SLIM_OFF_STX_DATA 4'h2
`define SLIM_OFF_SRX_DATA 4'h3
`define SLIM_OFF_ATX_DATA 4'h4
`define SLIM_OFF_ARX_DATA 4'h5
`define SLIM_OFF_ARX_CLEAR 4'h6
`define SLIM_CTRL_REFRAME 0
`define SLIM_CTRL_LEN_LO 1
`define SLIM_CTRL_LEN_HI 2
`define SLIM_STATUS_SRV 5
`define SLIM_CTRL_LEN_RST 2'h3
`define SLIM_STX_RST 10'h001
`define SLIM_SRX_MARK 9'h001
`define SLIM_ASY_RST 10'h3ff
`define SLIM_IDLE_CHAR 8'h16
`define SLIM_ASY_N 8'h10
`define SLIM_ASY_HALF 8'h08
`define SLIM_LEN_BASE 4'h5
`define SLIM_MAX_BIT_BPS 150
`define SLIM_MAX_SYNC_BPS 4800
`endif

// ---- logic/slim_pkg.sv ----
// types shared by the line interface
package slim_pkg;
	typedef enum logic [1:0] {
		ATX_IDLE = 2'b00,
		ATX_WAIT = 2'b01,
		ATX_PULSE = 2'b10,
		ATX_SEND = 2'b11
	} slim_atx_e;
	typedef struct packed {
		logic srv_req;
		logic srx_frame;
		logic srx_full;
		logic arx_full;
		logic atx_empty;
		logic stx_empty;
	} slim_status_s;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} slim_req_s;
endpackage

// ---- bench/slim_line_partner.sv ----
// terminal equipment model: line clocks, master timing, async and sync line traffic
module slim_line_partner (
	output logic tick,
	output logic stx_clk,
	output logic srx_clk,
	output logic srx_data,
	output logic arx_line,
	input wire logic atx_line
);
	timeunit 1ns;
	timeprecision 100ps;

	// master timing runs free; line clocks stand still outside frames
	initial begin
		tick = 1'b0;
		stx_clk = 1'b0;
		srx_clk = 1'b0;
		srx_data = 1'b1;
		arx_line = 1'b1;
		forever #62.5 tick = ~tick;
	end

	task automatic ticks(input int n);
		repeat (n) @(posedge tick);
	endtask

	task automatic stx_pulse();
		stx_clk = 1'b1;
		#62.5;
		stx_clk = 1'b0;
		#62.5;
	endtask

	// sync rx: msb first, data steady around the rising edge
	task automatic srx_send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			srx_data = b[i];
			#31;
			srx_clk = 1'b1;
			#62.5;
			srx_clk = 1'b0;
			#31.5;
		end
		// released: no stale level left behind
		srx_data = ~srx_data;
	endtask

	task automatic arx_send(input logic [7:0] d, input int len);
		arx_line = 1'b0;
		ticks(16);
		for (int i = 0; i < len; i++) begin
			arx_line = d[i];
			ticks(16);
		end
		arx_line = 1'b1;
		ticks(16);
	endtask

	// short low pulse, well under half a bit
	task automatic arx_glitch();
		arx_line = 1'b0;
		ticks(4);
		arx_line = 1'b1;
		ticks(200);
	endtask

	task automatic atx_recv(input int len, output logic [7:0] d, output int n, output logic ok);
		d = 8'h00;
		n = 0;
		while (atx_line !== 1'b0 && n < 200) begin
			@(posedge tick);
			n++;
		end
		ticks(8);
		ok = (atx_line === 1'b0);
		for (int i = 0; i < len; i++) begin
			ticks(16);
			d[i] = atx_line;
		end
		ticks(16);
		ok = ok & (atx_line === 1'b1);
	endtask
endmodule

// ---- bench/slim_line_if_test.sv ----
// self-checking bench for the serial line interface
`include "slim_defs.svh"
module slim_line_if_test import slim_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset_n, wr, rd, tick, stx_clk, srx_clk, srx_data, arx_line;
	logic stx_line, atx_line, cycle_req, ok;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, v;
	logic [7:0] ch [2];
	int fail_count, n_checks, n;

	slim_line_if i_slim_line_if (.clk(clk), .reset_n(reset_n), .ce(1'b1), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .stx_clk(stx_clk), .stx_line(stx_line), .srx_clk(srx_clk),
		.srx_data(srx_data), .tick(tick), .arx_line(arx_line), .atx_line(atx_line), .cycle_req(cycle_req));
	slim_line_partner i_slim_line_partner (.tick(tick), .stx_clk(stx_clk), .srx_clk(srx_clk),
		.srx_data(srx_data), .arx_line(arx_line), .atx_line(atx_line));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// gap cycle after each strobe so no signal is driven twice in one step
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask

	task automatic wait_stat(input int b, input logic val);
		for (int i = 0; i < 3000; i++) begin
			rd_reg(`SLIM_OFF_STATUS, v);
			if (v[b] === val)
				break;
		end
		chk("status wait", {7'h0, v[b]}, {7'h0, val});
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		#300_000;
		fail_count++;
		test_done();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		ch = '{8'hA5, 8'h5A};
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk("stx_line", {7'h0, stx_line}, 8'h01);
		chk("atx_line", {7'h0, atx_line}, 8'h01);
		chk("cycle_req", {7'h0, cycle_req}, 8'h01);
		rd_reg(`SLIM_OFF_STATUS, v);
		chk("status", v, 8'h03);
		rd_reg(4'hf, v);
		chk("unmapped", v, 8'h00);
		$display("test reset done");

		// both transmitters busy: no request to the scanner
		wr_reg(`SLIM_OFF_STX_DATA, ch[0]);
		wr_reg(`SLIM_OFF_ATX_DATA, 8'h4B);
		wr_reg(`SLIM_OFF_ATX_DATA, 8'hFF);
		chk("cycle_req busy", {7'h0, cycle_req}, 8'h00);
		rd_reg(`SLIM_OFF_STATUS, v);
		chk("status busy", v, 8'h00);
		i_slim_line_partner.atx_recv(8, v, n, ok);
		chk("atx data", v, 8'h4B);
		chk("atx frame", {7'h0, ok}, 8'h01);
		chk("atx start delay", {7'h0, (n >= 31 && n <= 34)}, 8'h01);
		@(posedge clk);
		rd_reg(`SLIM_OFF_STATUS, v);
		chk("atx empty", {7'h0, v[1]}, 8'h01);
		i_slim_line_partner.ticks(40);
		@(posedge clk);
		chk("atx idle line", {7'h0, atx_line}, 8'h01);
		$display("test async tx done");

		// first load already taken above; the repeat write is refused
		for (int c = 0; c < 2; c++) begin
			wr_reg(`SLIM_OFF_STX_DATA, ch[c]);
			for (int k = 1; k <= 9; k++) begin
				if (k == 3)
					wr_reg(`SLIM_OFF_STX_DATA, 8'hFF);
				i_slim_line_partner.stx_pulse();
				@(posedge clk);
				chk("stx bit", {7'h0, stx_line}, (k < 9) ? {7'h0, ch[c][k-1]} : 8'h01);
				if (k >= 7 && k <= 8) begin
					rd_reg(`SLIM_OFF_STATUS, v);
					chk("stx empty", {7'h0, v[0]}, (k == 8) ? 8'h01 : 8'h00);
				end
			end
		end
		$display("test sync tx done");

		i_slim_line_partner.arx_glitch();
		@(posedge clk);
		rd_reg(`SLIM_OFF_STATUS, v);
		chk("arx glitch", {7'h0, v[2]}, 8'h00);
		for (int len = 5; len <= 8; len++) begin
			wr_reg(`SLIM_OFF_CTRL, 8'((len - 5) << 1));
			rd_reg(`SLIM_OFF_CTRL, v);
			chk("ctrl len", v, 8'((len - 5) << 1));
			i_slim_line_partner.arx_send(8'hB6, len);
			@(posedge clk);
			wait_stat(2, 1'b1);
			rd_reg(`SLIM_OFF_ARX_DATA, v);
			chk("arx data", v, 8'hB6 & 8'((16'h1 << len) - 1));
			wr_reg(`SLIM_OFF_ARX_CLEAR, 8'h00);
			rd_reg(`SLIM_OFF_STATUS, v);
			chk("arx cleared", {7'h0, v[2]}, 8'h00);
		end
		$display("test async rx done");

		i_slim_line_partner.srx_send(`SLIM_IDLE_CHAR);
		i_slim_line_partner.srx_send(8'hC3);
		@(posedge clk);
		wait_stat(3, 1'b1);
		rd_reg(`SLIM_OFF_STATUS, v);
		chk("srx status", v, 8'h3B);
		rd_reg(`SLIM_OFF_SRX_DATA, v);
		chk("srx data", v, 8'hC3);
		wr_reg(`SLIM_OFF_STATUS, 8'h20);
		rd_reg(`SLIM_OFF_STATUS, v);
		chk("srx after read", v, 8'h13);
		$display("test sync rx done");
		test_done();
	end
endmodule
